// [hdl/pmt_pkg.sv]
// Package for the 8-bit period match timer: register map, fields, resets.
// Assumes a plain register port with one-cycle read latency.
package pmt_pkg;
   localparam int unsigned CLK_HZ        = 100_000_000;
   localparam logic [1:0]  ADDR_CONTROL  = 2'h0;
   localparam logic [1:0]  ADDR_COUNT    = 2'h1;
   localparam logic [1:0]  ADDR_PERIOD   = 2'h2;
   localparam logic [1:0]  ADDR_IRQ      = 2'h3;
   localparam logic [7:0]  COUNT_RESET   = 8'h00;
   localparam logic [7:0]  PERIOD_RESET  = 8'hff;
   localparam logic [6:0]  CONTROL_RESET = 7'h00;
   localparam int unsigned INSTR_DIV     = 4;
   localparam logic [5:0]  PRE_LAST_1    = 6'h00;
   localparam logic [5:0]  PRE_LAST_4    = 6'h03;
   localparam logic [5:0]  PRE_LAST_16   = 6'h0f;
   localparam logic [5:0]  PRE_LAST_64   = 6'h3f;
   localparam logic [1:0]  INSTR_LAST    = 2'h3;
   localparam int unsigned CTRL_ON_BIT   = 2;
   localparam int unsigned IRQ_FLAG_BIT  = 0;
   localparam int unsigned IRQ_EN_BIT    = 1;
   localparam int unsigned IRQ_SLEEP_BIT = 2;
   localparam int unsigned IRQ_SPI_BIT   = 3;

   typedef struct packed {
      logic [3:0] postscaleSelect;
      logic       timerOn;
      logic [1:0] prescaleSelect;
   } pmt_control_t;

   typedef struct packed {
      logic [1:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } pmt_bus_t;
endpackage

// [hdl/pmt_prescaler.sv]
// Prescaler: divides instruction ticks by 1, 4, 16 or 64.
// Assumes tickIn is a one-cycle pulse in the system clock domain.
`timescale 1ns/10ps
`default_nettype none
module pmt_prescaler (
   input  wire logic       clock,
   input  wire logic       rst_n,
   input  wire logic       clear,
   input  wire logic       tickIn,
   input  wire logic [1:0] prescaleSelect,
   output logic            tickOut
);
   typedef struct packed {
      logic [5:0] count;
   } pmt_pre_state_t;

   pmt_pre_state_t state_r;
   pmt_pre_state_t state_nxt;
   logic [5:0]     lastCount;

   // Terminal count for the selected ratio
   always_comb begin
      unique case (prescaleSelect)
         2'h0: lastCount = pmt_pkg::PRE_LAST_1;
         2'h1: lastCount = pmt_pkg::PRE_LAST_4;
         2'h2: lastCount = pmt_pkg::PRE_LAST_16;
         2'h3: lastCount = pmt_pkg::PRE_LAST_64;
      endcase
   end

   assign tickOut = tickIn && (state_r.count >= lastCount);

   // Next-state of the divider
   always_comb begin
      state_nxt = state_r;
      if (clear) begin
         state_nxt.count = 6'h00;
      end else if (tickIn) begin
         state_nxt.count = tickOut ? 6'h00 : state_r.count + 6'h01;
      end
   end

   // State register
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= '0;
      end else begin
         state_r <= state_nxt;
      end
   end
endmodule
`default_nettype wire

// [hdl/pmt_postscaler.sv]
// Postscaler: counts match pulses, fires every (select+1) matches.
// Assumes matchIn is a one-cycle pulse.
`timescale 1ns/10ps
`default_nettype none
module pmt_postscaler (
   input  wire logic       clock,
   input  wire logic       rst_n,
   input  wire logic       clear,
   input  wire logic       matchIn,
   input  wire logic [3:0] postscaleSelect,
   output logic            fire
);
   typedef struct packed {
      logic [3:0] count;
   } pmt_post_state_t;

   pmt_post_state_t state_r;
   pmt_post_state_t state_nxt;

   assign fire = matchIn && (state_r.count >= postscaleSelect);

   // Next-state of the match counter
   always_comb begin
      state_nxt = state_r;
      if (clear) begin
         state_nxt.count = 4'h0;
      end else if (matchIn) begin
         state_nxt.count = fire ? 4'h0 : state_r.count + 4'h1;
      end
   end

   // State register
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= '0;
      end else begin
         state_r <= state_nxt;
      end
   end
endmodule
`default_nettype wire

// [hdl/pmt_timer.sv]
// Top of the 8-bit period match timer with control, count and period regs.
// Assumes a plain register port; the system clock is the oscillator.
//
// Notes on behaviour
// - The timer ticks at the instruction rate, one quarter of the clock, via the prescaler.
// - Prescale select codes 0..3 divide the instruction tick by 1, 4, 16 or 64.
// - Each prescaled tick compares count with period and pulses the match output on equality.
// - A match loads zero into the count instead of incrementing and advances the postscaler.
// - Reset clears the count and sets the period to all ones.
// - Writes to the count or control register and any reset clear both scalers.
// - Writing the control register leaves the count untouched.
// - The postscaler counts matches and sets a sticky match flag at its terminal count.
// - The interrupt request is forwarded only while the match enable bit is one.
// - Postscale code n gives a ratio of 1:(n+1), from 1:1 to 1:16.
// - The unscaled match pulse is offered to the capture/compare/PWM logic.
// - The match pulse can be selected as the serial port shift clock in SPI mode.
// - In Sleep the timer stops and the count and period keep their values.
// - Count and period are readable and writable at any time.
// - The period is the period value plus one prescaled ticks.
`timescale 1ns/10ps
`default_nettype none
module pmt_timer (
   input  wire logic       clock,
   input  wire logic       rst_n,
   input  wire logic [1:0] regAddr,
   input  wire logic [7:0] regWdata,
   input  wire logic       regWrite,
   input  wire logic       regRead,
   output logic      [7:0] regRdata,
   input  wire logic       sleepMode,
   output logic            matchPulse,
   output logic            ccpTimeBase,
   output logic            spiShiftClock,
   output logic            matchIrq
);
   typedef struct packed {
      pmt_pkg::pmt_control_t control;
      logic [7:0]            count;
      logic [7:0]            period;
      logic                  irqFlag;
      logic                  irqEnable;
      logic                  spiSelect;
      logic [1:0]            instrDiv;
      logic [7:0]            rdata;
   } pmt_state_t;

   pmt_state_t       state_r;
   pmt_state_t       state_nxt;
   pmt_pkg::pmt_bus_t bus;
   logic             instrTick;
   logic             preTick;
   logic             scalerClear;
   logic             postFire;
   logic             countWrite;
   logic             controlWrite;
   logic             irqWrite;
   logic             periodWrite;

   // Write strobe decode for one register index
   function automatic logic wrHit(input pmt_pkg::pmt_bus_t b, input logic [1:0] a);
      return b.wr && (b.addr == a);
   endfunction

   assign bus = '{addr: regAddr, wdata: regWdata, wr: regWrite, rd: regRead};

   // Address decode of write strobes
   assign controlWrite = wrHit(bus, pmt_pkg::ADDR_CONTROL);
   assign countWrite   = wrHit(bus, pmt_pkg::ADDR_COUNT);
   assign periodWrite  = wrHit(bus, pmt_pkg::ADDR_PERIOD);
   assign irqWrite     = wrHit(bus, pmt_pkg::ADDR_IRQ);
   assign scalerClear  = controlWrite || countWrite;

   // Instruction tick, gated by enable and Sleep
   assign instrTick = (state_r.instrDiv == pmt_pkg::INSTR_LAST)
                      && state_r.control.timerOn && !sleepMode;

   // Match only on a prescaled tick with equal values
   assign matchPulse    = preTick && (state_r.count == state_r.period);
   assign ccpTimeBase   = matchPulse;
   assign spiShiftClock = state_r.spiSelect && matchPulse;
   assign matchIrq      = state_r.irqFlag && state_r.irqEnable;
   assign regRdata      = state_r.rdata;

   pmt_prescaler u_pre (
      .clock          (clock),
      .rst_n          (rst_n),
      .clear          (scalerClear),
      .tickIn         (instrTick),
      .prescaleSelect (state_r.control.prescaleSelect),
      .tickOut        (preTick)
   );

   pmt_postscaler u_post (
      .clock           (clock),
      .rst_n           (rst_n),
      .clear           (scalerClear),
      .matchIn         (matchPulse),
      .postscaleSelect (state_r.control.postscaleSelect),
      .fire            (postFire)
   );

   // Next-state: counter, registers and read data
   always_comb begin
      state_nxt = state_r;
      if (!sleepMode) begin
         state_nxt.instrDiv = state_r.instrDiv + 2'h1;
      end
      if (matchPulse) begin
         state_nxt.count = pmt_pkg::COUNT_RESET;
      end else if (preTick) begin
         state_nxt.count = state_r.count + 8'h01;
      end
      if (countWrite) begin
         state_nxt.count = bus.wdata;
      end
      if (periodWrite) begin
         state_nxt.period = bus.wdata;
      end
      if (controlWrite) begin
         state_nxt.control = bus.wdata[6:0];
      end
      if (irqWrite) begin
         state_nxt.irqFlag   = bus.wdata[pmt_pkg::IRQ_FLAG_BIT];
         state_nxt.irqEnable = bus.wdata[pmt_pkg::IRQ_EN_BIT];
         state_nxt.spiSelect = bus.wdata[pmt_pkg::IRQ_SPI_BIT];
      end
      if (postFire) begin
         state_nxt.irqFlag = 1'b1;
      end
      state_nxt.rdata = 8'h00;
      if (bus.rd) begin
         unique case (bus.addr)
            pmt_pkg::ADDR_CONTROL: state_nxt.rdata = {1'b0, state_r.control};
            pmt_pkg::ADDR_COUNT:   state_nxt.rdata = state_r.count;
            pmt_pkg::ADDR_PERIOD:  state_nxt.rdata = state_r.period;
            pmt_pkg::ADDR_IRQ:     state_nxt.rdata = {4'h0, state_r.spiSelect, sleepMode,
                                                      state_r.irqEnable, state_r.irqFlag};
         endcase
      end
   end

   // State register with reset values
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_r           <= '0;
         state_r.count     <= pmt_pkg::COUNT_RESET;
         state_r.period    <= pmt_pkg::PERIOD_RESET;
         state_r.control   <= pmt_pkg::CONTROL_RESET;
      end else begin
         state_r <= state_nxt;
      end
   end
endmodule
`default_nettype wire

// [tb/pmt_timer_assertions.sv]
// Port checker for the period match timer, bound to each timer instance.
// Assumes the bench never raises a read strobe and a write strobe together.
`timescale 1ns/10ps
`default_nettype none
module pmt_timer_assertions (
   input wire logic       clock,
   input wire logic       rst_n,
   input wire logic [1:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic       regWrite,
   input wire logic       regRead,
   input wire logic [7:0] regRdata,
   input wire logic       sleepMode,
   input wire logic       matchPulse,
   input wire logic       ccpTimeBase,
   input wire logic       spiShiftClock,
   input wire logic       matchIrq
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   // Write one register, idle a cycle, then read it back
   sequence s_wr_rd(logic [1:0] a);
      regWrite && regAddr == a ##2 regRead && regAddr == a;
   endsequence
   a_rdata_idle: assert property (!$past(regRead) |-> regRdata == 8'h00)
      else $error("read data not zero outside read slot");
   a_period_back: assert property (s_wr_rd(pmt_pkg::ADDR_PERIOD)
         |=> regRdata == $past(regWdata, 3))
      else $error("period readback wrong");
   a_control_back: assert property (s_wr_rd(pmt_pkg::ADDR_CONTROL)
         |=> regRdata == ($past(regWdata, 3) & 8'h7f))
      else $error("control readback wrong");
   a_match_spacing: assert property (matchPulse |=> !matchPulse [*3])
      else $error("match pulses closer than one instruction tick");
   a_ccp_follows: assert property (ccpTimeBase == matchPulse)
      else $error("time base differs from match");
   a_spi_gated: assert property (spiShiftClock |-> matchPulse)
      else $error("shift clock without match");
   a_sleep_quiet: assert property (sleepMode |-> !matchPulse)
      else $error("match during sleep");
   a_irq_enabled: assert property (regRead && regAddr == pmt_pkg::ADDR_IRQ && matchIrq
         |=> regRdata[1:0] == 2'b11)
      else $error("request without flag and enable");
endmodule
bind pmt_timer pmt_timer_assertions u_chk (.clock(clock), .rst_n(rst_n), .regAddr(regAddr),
   .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
   .sleepMode(sleepMode), .matchPulse(matchPulse), .ccpTimeBase(ccpTimeBase),
   .spiShiftClock(spiShiftClock), .matchIrq(matchIrq));
`default_nettype wire

// [tb/testbench.sv]
// Self-checking bench for the period match timer, random with fixed seed.
// Assumes the register port answers reads one cycle after the strobe.
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic       clock = 1'b0;
   logic       rst_n = 1'b0;
   logic [1:0] regAddr = 2'h0;
   logic [7:0] regWdata = 8'h00;
   logic       regWrite = 1'b0;
   logic       regRead = 1'b0;
   logic       sleepMode = 1'b0;
   logic [7:0] regRdata, d, v;
   logic       matchPulse, ccpTimeBase, spiShiftClock, matchIrq;
   int         errors = 0;
   int         samples_checked = 0;
   int         n, m, p, ps;
   // Free-running 100 MHz clock
   always #5 clock = ~clock;
   pmt_timer u_dut (.clock(clock), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
      .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .sleepMode(sleepMode),
      .matchPulse(matchPulse), .ccpTimeBase(ccpTimeBase), .spiShiftClock(spiShiftClock),
      .matchIrq(matchIrq));
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic end_of_test();
      $display("errors %0d samples_checked %0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic wr(input logic [1:0] a, input logic [7:0] w);
      @(posedge clock);
      regAddr <= a;
      regWdata <= w;
      regWrite <= 1'b1;
      @(posedge clock);
      regWrite <= 1'b0;
   endtask
   task automatic rd(input logic [1:0] a, output logic [7:0] r);
      @(posedge clock);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clock);
      regRead <= 1'b0;
      @(negedge clock);
      r = regRdata;
   endtask
   // Cycles between two match pulses, seen at falling edges
   task automatic gap(output int g);
      @(negedge clock);
      while (matchPulse !== 1'b1) @(negedge clock);
      @(negedge clock);
      g = 1;
      while (matchPulse !== 1'b1 && g < 9000) begin
         @(negedge clock);
         g++;
      end
   endtask
   // Expected match period in system clocks
   function automatic int gapExp(int code, int per);
      return 4 * (1 << (2 * code)) * (per + 1);
   endfunction
   // Hang guard, well beyond the few thousand cycles the tests need
   initial begin
      #400000;
      errors++;
      end_of_test();
   end
   // Main sequence
   initial begin
      void'($urandom(32'hd151));
      repeat (8) @(posedge clock);
      rst_n <= 1'b1;
      rd(pmt_pkg::ADDR_COUNT, d);
      check("count reset", d, pmt_pkg::COUNT_RESET);
      rd(pmt_pkg::ADDR_PERIOD, d);
      check("period reset", d, pmt_pkg::PERIOD_RESET);
      v = 8'($urandom);
      wr(pmt_pkg::ADDR_PERIOD, v);
      rd(pmt_pkg::ADDR_PERIOD, d);
      check("period readback", d, v);
      wr(pmt_pkg::ADDR_CONTROL, 8'hff);
      rd(pmt_pkg::ADDR_CONTROL, d);
      check("control readback", d, 8'h7f);
      $display("registers test done");
      for (ps = 0; ps < 4; ps++) begin
         p = $urandom_range(3, 1);
         wr(pmt_pkg::ADDR_PERIOD, p[7:0]);
         wr(pmt_pkg::ADDR_CONTROL, {6'h01, ps[1:0]});
         wr(pmt_pkg::ADDR_COUNT, 8'h00);
         gap(n);
         check("match gap", n, gapExp(ps, p));
      end
      $display("prescale test done");
      n = $urandom_range(15, 0);
      wr(pmt_pkg::ADDR_CONTROL, 8'h00);
      wr(pmt_pkg::ADDR_IRQ, 8'h02);
      wr(pmt_pkg::ADDR_PERIOD, 8'h01);
      wr(pmt_pkg::ADDR_COUNT, 8'h00);
      wr(pmt_pkg::ADDR_CONTROL, {1'b0, n[3:0], 3'b100});
      m = 0;
      while (matchIrq !== 1'b1 && m < 20) begin
         @(negedge clock);
         if (matchPulse === 1'b1)
            m++;
      end
      check("postscale matches", m, n + 1);
      wr(pmt_pkg::ADDR_IRQ, 8'h01);
      @(negedge clock);
      check("masked request", matchIrq, 1'b0);
      wr(pmt_pkg::ADDR_IRQ, 8'h0b);
      rd(pmt_pkg::ADDR_IRQ, d);
      check("flag and enable", d[1:0], 2'b11);
      gap(n);
      check("spi clock", spiShiftClock, 1'b1);
      check("time base", ccpTimeBase, 1'b1);
      // Control write mid-way restarts the postscale count
      wr(pmt_pkg::ADDR_CONTROL, 8'h18);
      wr(pmt_pkg::ADDR_IRQ, 8'h02);
      wr(pmt_pkg::ADDR_CONTROL, 8'h1c);
      m = 0;
      while (m < 2) begin
         @(negedge clock);
         if (matchPulse === 1'b1)
            m++;
      end
      check("no early flag", matchIrq, 1'b0);
      wr(pmt_pkg::ADDR_CONTROL, 8'h1c);
      m = 0;
      while (matchIrq !== 1'b1 && m < 20) begin
         @(negedge clock);
         if (matchPulse === 1'b1)
            m++;
      end
      check("scaler clear", m, 4);
      $display("postscale test done");
      v = 8'($urandom);
      wr(pmt_pkg::ADDR_CONTROL, 8'h00);
      wr(pmt_pkg::ADDR_COUNT, v);
      wr(pmt_pkg::ADDR_CONTROL, 8'h03);
      rd(pmt_pkg::ADDR_COUNT, d);
      check("count kept", d, v);
      wr(pmt_pkg::ADDR_CONTROL, 8'h04);
      sleepMode <= 1'b1;
      rd(pmt_pkg::ADDR_COUNT, v);
      repeat (20) @(posedge clock);
      rd(pmt_pkg::ADDR_COUNT, d);
      check("sleep hold", d, v);
      sleepMode <= 1'b0;
      $display("hold test done");
      // Reset in mid-run restores count and period
      wr(pmt_pkg::ADDR_PERIOD, 8'h5a);
      rst_n <= 1'b0;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      rd(pmt_pkg::ADDR_PERIOD, d);
      check("period after reset", d, pmt_pkg::PERIOD_RESET);
      rd(pmt_pkg::ADDR_COUNT, d);
      check("count after reset", d, pmt_pkg::COUNT_RESET);
      $display("reset test done");
      end_of_test();
   end
endmodule
`default_nettype wire
